// file: spc_pkg.sv
// Constants shared by the serial port 0 control block
package spc_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] SPC_CTRL_ADDR = 8'h98; // Control register
  localparam logic [7:0] SPC_CTRL_RESET = 8'h00; // Value after reset
  localparam logic [4:0] SPC_BIT_BLOCK = 5'h13; // Bit addresses 98H-9FH

  // ==========================================================
  // Field positions inside the control register
  localparam int SPC_MODE_HIGH_BIT = 7; // Mode high or frame error
  localparam int SPC_MODE_LOW_BIT = 6;
  localparam int SPC_MP_CHECK_BIT = 5;
  localparam int SPC_RX_ENABLE_BIT = 4;
  localparam int SPC_TX_NINTH_BIT = 3;
  localparam int SPC_RX_NINTH_BIT = 2;
  localparam int SPC_TX_DONE_BIT = 1;
  localparam int SPC_RX_DONE_BIT = 0;

  // ==========================================================
  // Mode field encoding
  localparam logic [1:0] SPC_MODE_SHIFT = 2'h0; // Synchronous shift
  localparam logic [1:0] SPC_MODE_8BIT_VAR = 2'h1; // 8-bit, variable
  localparam logic [1:0] SPC_MODE_9BIT_FIX = 2'h2; // 9-bit, fixed
  localparam logic [1:0] SPC_MODE_9BIT_VAR = 2'h3; // 9-bit, variable

  // ==========================================================
  // Shift clock divisors of the system clock in mode 0
  localparam int SPC_SHIFT_DIV_SLOW = 12;
  localparam int SPC_SHIFT_DIV_FAST = 2;
  localparam int SPC_SHIFT_CNT_W = 4;

endpackage

// file: spc_remote_model.sv
// Remote serial device model feeding frame events to the control block
`timescale 1ns/10ps
module spc_remote_model (
  input wire logic sys_clk, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic sendReq, // Offer one async frame
  input wire logic shiftReq, // Offer one mode 0 byte
  input wire logic txReq, // Line took a transmit frame
  input wire logic [7:0] sendByte, // Frame data to offer
  input wire logic sendNinth, // Ninth bit to offer
  input wire logic sendStop, // Stop level to offer
  output logic rxFrameDone, // Stop bit sampled pulse
  output logic rxShiftDone, // Mode 0 eighth bit pulse
  output logic txFrameDone, // Transmit end pulse
  output logic [7:0] rxByte, // Received data
  output logic rxNinthBit, // Received ninth bit
  output logic rxStopBit // Sampled stop level
);
  // ==========================================================
  // Event pulses, one cycle after each request
  always_ff @(posedge sys_clk) begin
    rxFrameDone <= !rst && sendReq;
    rxShiftDone <= !rst && shiftReq;
    txFrameDone <= !rst && txReq;
  end

  // Frame data, scrambled every cycle while no frame is offered
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rxByte <= 8'h5A;
      rxNinthBit <= 1'b0;
      rxStopBit <= 1'b1;
    end else begin
      rxByte <= sendReq ? sendByte : ~rxByte;
      rxNinthBit <= sendReq ? sendNinth : ~rxNinthBit;
      rxStopBit <= sendReq ? sendStop : ~rxStopBit;
    end
  end
endmodule

// file: spc_serial_control.sv
// Control and status register logic of serial port 0
`timescale 1ns/10ps

// What this block does
// - Bits 7:6 are mode when access off
// - Bit 7 is frame error when access on
// - Missing stop bit sets sticky frame error
// - Mode 0 rate: divide twelve or two
// - Mode 1, check off: every frame valid
// - Mode 1, check on: stop and address
// - Modes 2/3, check on: ninth and address
// - Given is AND, broadcast is OR
// - Receive enable low ignores incoming frames
// - Mode 0 starts receive: enabled, flag clear
// - Ninth transmit bit sent in modes 2/3
// - Ninth receive bit: ninth or stop level
// - Transmit flag set at frame end
// - Receive flag set after valid frame
// - Flags request interrupt, software clears only
// - Register at 98H, bit addressable, resets zero
module spc_serial_control
  import spc_pkg::*;
(
  input wire logic sys_clk, // System clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic [7:0] sfrAddr, // Byte access address
  input wire logic sfrWrite, // Byte write strobe
  input wire logic [7:0] sfrWriteData, // Byte write data
  input wire logic [7:0] sfrBitAddr, // Bit access address
  input wire logic sfrBitWrite, // Bit write strobe
  input wire logic sfrBitValue, // Bit write value
  output logic [7:0] sfrReadData, // Read data, one cycle late
  input wire logic frameErrorAccessSelect, // Bit 7 shows frame error
  input wire logic [7:0] slaveAddress, // Own slave address
  input wire logic [7:0] slaveAddressMask, // Slave address mask
  input wire logic txFrameDone, // Transmit frame finished pulse
  input wire logic rxShiftDone, // Mode 0 eighth bit received
  input wire logic rxFrameDone, // Modes 1-3 stop bit sampled
  input wire logic [7:0] rxByte, // Received data byte
  input wire logic rxNinthBit, // Received ninth bit
  input wire logic rxStopBit, // Sampled stop bit level
  output logic [1:0] modeSelect, // Operating mode field
  output logic multiprocessorCheckEnable, // Check bit
  output logic receiveEnable, // Reception allowed, modes 1-3
  output logic ninthTransmitBit, // Ninth bit to send
  output logic mode0ReceiveStart, // Mode 0 reception may start
  output logic shiftClockTick, // Mode 0 shift clock tick
  output logic serialIrq, // Serial interrupt request
  output logic rxAccepted, // Valid reception pulse
  output logic framingErrorFlag // Framing error status
);

  // ==========================================================
  // Register state
  logic modeHigh_reg, modeHigh_next;
  logic modeLow_reg, modeLow_next;
  logic mpCheck_reg, mpCheck_next;
  logic rxEnable_reg, rxEnable_next;
  logic txNinth_reg, txNinth_next;
  logic rxNinth_reg, rxNinth_next;
  logic txDone_reg, txDone_next;
  logic rxDone_reg, rxDone_next;
  logic frameError_reg, frameError_next;
  logic [7:0] readData_reg;
  logic irq_reg;
  logic rxAccepted_reg;
  logic txNinthOut_reg;
  logic rxEnableOut_reg;
  logic mode0Start_reg;

  logic byteHit, bitHit;
  logic [2:0] bitIdx;
  logic [7:0] swWe, swVal;
  logic [1:0] mode;
  logic [7:0] givenAddr, bcastAddr;
  logic addrMatch, rxValid, frameErrSet;
  logic [7:0] regView;

  assign mode = {modeHigh_reg, modeLow_reg};
  assign bitIdx = sfrBitAddr[2:0];

  // ==========================================================
  // Access decode
  // Byte and bit writes to the control register
  assign byteHit = sfrWrite && (sfrAddr == SPC_CTRL_ADDR);
  assign bitHit = sfrBitWrite &&
                  (sfrBitAddr[7:3] == SPC_BIT_BLOCK);

  // Per-bit write enables and values
  always_comb begin
    swWe = 8'h00;
    swVal = 8'h00;
    if (byteHit) begin
      swWe = 8'hFF;
      swVal = sfrWriteData;
    end else if (bitHit) begin
      swWe[bitIdx] = 1'b1;
      swVal[bitIdx] = sfrBitValue;
    end
  end

  // ==========================================================
  // Reception validity
  // Given and broadcast address comparison
  assign givenAddr = slaveAddress & slaveAddressMask;
  assign bcastAddr = slaveAddress | slaveAddressMask;
  assign addrMatch =
    ((rxByte & slaveAddressMask) == givenAddr) ||
    ((rxByte & bcastAddr) == bcastAddr);

  // Frame acceptance by mode and check bit
  always_comb begin
    rxValid = 1'b0;
    case (mode)
      SPC_MODE_SHIFT: begin
        rxValid = rxShiftDone && rxEnable_reg;
      end
      SPC_MODE_8BIT_VAR: begin
        rxValid = rxFrameDone && rxEnable_reg &&
                  (!mpCheck_reg ||
                   (rxStopBit && addrMatch));
      end
      SPC_MODE_9BIT_FIX, SPC_MODE_9BIT_VAR: begin
        rxValid = rxFrameDone && rxEnable_reg &&
                  (!mpCheck_reg ||
                   (rxNinthBit && addrMatch));
      end
      default: begin
        rxValid = 1'b0;
      end
    endcase
  end

  // Missing stop bit in the asynchronous modes
  assign frameErrSet = rxFrameDone && rxEnable_reg &&
                       (mode != SPC_MODE_SHIFT) && !rxStopBit;

  // ==========================================================
  // Next values of the control bits
  // Bit 7 goes to mode or frame error by access select
  always_comb begin
    modeHigh_next = modeHigh_reg;
    frameError_next = frameError_reg;
    if (swWe[SPC_MODE_HIGH_BIT] && !frameErrorAccessSelect) begin
      modeHigh_next = swVal[SPC_MODE_HIGH_BIT];
    end
    if (swWe[SPC_MODE_HIGH_BIT] && frameErrorAccessSelect) begin
      frameError_next = swVal[SPC_MODE_HIGH_BIT];
    end
    if (frameErrSet) begin
      frameError_next = 1'b1;
    end
  end

  // Plain software bits
  always_comb begin
    modeLow_next = swWe[SPC_MODE_LOW_BIT] ?
                   swVal[SPC_MODE_LOW_BIT] : modeLow_reg;
    mpCheck_next = swWe[SPC_MP_CHECK_BIT] ?
                   swVal[SPC_MP_CHECK_BIT] : mpCheck_reg;
    rxEnable_next = swWe[SPC_RX_ENABLE_BIT] ?
                    swVal[SPC_RX_ENABLE_BIT] : rxEnable_reg;
    txNinth_next = swWe[SPC_TX_NINTH_BIT] ?
                   swVal[SPC_TX_NINTH_BIT] : txNinth_reg;
  end

  // Received ninth bit, hardware store wins over software
  always_comb begin
    rxNinth_next = swWe[SPC_RX_NINTH_BIT] ?
                   swVal[SPC_RX_NINTH_BIT] : rxNinth_reg;
    if (rxValid && mode == SPC_MODE_8BIT_VAR) begin
      rxNinth_next = rxStopBit;
    end else if (rxValid && mode[1]) begin
      rxNinth_next = rxNinthBit;
    end
  end

  // Done flags: hardware set wins over software clear
  always_comb begin
    txDone_next = swWe[SPC_TX_DONE_BIT] ?
                  swVal[SPC_TX_DONE_BIT] : txDone_reg;
    rxDone_next = swWe[SPC_RX_DONE_BIT] ?
                  swVal[SPC_RX_DONE_BIT] : rxDone_reg;
    if (txFrameDone) begin
      txDone_next = 1'b1;
    end
    if (rxValid) begin
      rxDone_next = 1'b1;
    end
  end

  // ==========================================================
  // Registers
  // Control bits, all zero after reset
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      modeHigh_reg <= SPC_CTRL_RESET[SPC_MODE_HIGH_BIT];
      modeLow_reg <= SPC_CTRL_RESET[SPC_MODE_LOW_BIT];
      mpCheck_reg <= SPC_CTRL_RESET[SPC_MP_CHECK_BIT];
      rxEnable_reg <= SPC_CTRL_RESET[SPC_RX_ENABLE_BIT];
      txNinth_reg <= SPC_CTRL_RESET[SPC_TX_NINTH_BIT];
      rxNinth_reg <= SPC_CTRL_RESET[SPC_RX_NINTH_BIT];
      txDone_reg <= SPC_CTRL_RESET[SPC_TX_DONE_BIT];
      rxDone_reg <= SPC_CTRL_RESET[SPC_RX_DONE_BIT];
      frameError_reg <= 1'b0;
    end else begin
      modeHigh_reg <= modeHigh_next;
      modeLow_reg <= modeLow_next;
      mpCheck_reg <= mpCheck_next;
      rxEnable_reg <= rxEnable_next;
      txNinth_reg <= txNinth_next;
      rxNinth_reg <= rxNinth_next;
      txDone_reg <= txDone_next;
      rxDone_reg <= rxDone_next;
      frameError_reg <= frameError_next;
    end
  end

  // Register view seen by reads
  assign regView = {frameErrorAccessSelect ? frameError_reg
                                           : modeHigh_reg,
                    modeLow_reg, mpCheck_reg, rxEnable_reg,
                    txNinth_reg, rxNinth_reg, txDone_reg, rxDone_reg};

  // Read data, zero for other addresses
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      readData_reg <= 8'h00;
    end else if (sfrAddr == SPC_CTRL_ADDR) begin
      readData_reg <= regView;
    end else begin
      readData_reg <= 8'h00;
    end
  end

  // Status outputs aligned with the control bits
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_reg <= 1'b0;
      rxAccepted_reg <= 1'b0;
      txNinthOut_reg <= 1'b0;
      rxEnableOut_reg <= 1'b0;
      mode0Start_reg <= 1'b0;
    end else begin
      irq_reg <= txDone_next || rxDone_next;
      rxAccepted_reg <= rxValid;
      txNinthOut_reg <= txNinth_next && modeHigh_next;
      rxEnableOut_reg <= rxEnable_next &&
                         ({modeHigh_next, modeLow_next} !=
                          SPC_MODE_SHIFT);
      mode0Start_reg <= ({modeHigh_next, modeLow_next} ==
                         SPC_MODE_SHIFT) &&
                        rxEnable_next && !rxDone_next;
    end
  end

  // ==========================================================
  // Mode 0 shift clock
  spc_shift_divider #(
    .SLOW_DIV(SPC_SHIFT_DIV_SLOW),
    .FAST_DIV(SPC_SHIFT_DIV_FAST),
    .CNT_W(SPC_SHIFT_CNT_W)
  ) shiftDivider (
    .sys_clk(sys_clk),
    .rst(rst),
    .runEnable(mode == SPC_MODE_SHIFT),
    .fastSelect(mpCheck_reg),
    .shiftTick(shiftClockTick)
  );

  // Output connections
  assign sfrReadData = readData_reg;
  assign modeSelect = {modeHigh_reg, modeLow_reg};
  assign multiprocessorCheckEnable = mpCheck_reg;
  assign receiveEnable = rxEnableOut_reg;
  assign ninthTransmitBit = txNinthOut_reg;
  assign mode0ReceiveStart = mode0Start_reg;
  assign serialIrq = irq_reg;
  assign rxAccepted = rxAccepted_reg;
  assign framingErrorFlag = frameError_reg;

  // ==========================================================
  // Assertions
  logic slowRun, fastRun, rxSwSet, rxSwClr, feSwClr;
  assign slowRun = (mode == SPC_MODE_SHIFT) && !mpCheck_reg;
  assign fastRun = (mode == SPC_MODE_SHIFT) && mpCheck_reg;
  assign rxSwSet = swWe[SPC_RX_DONE_BIT] && swVal[SPC_RX_DONE_BIT];
  assign rxSwClr = swWe[SPC_RX_DONE_BIT] && !swVal[SPC_RX_DONE_BIT];
  assign feSwClr = swWe[SPC_MODE_HIGH_BIT] && frameErrorAccessSelect &&
                   !swVal[SPC_MODE_HIGH_BIT];

  sequence fastTwice;
    (fastRun && shiftClockTick) ##1 fastRun;
  endsequence

  sequence rxQuiet;
    !rxDone_reg && !rxSwSet;
  endsequence

  a_mode_write: assert property (@(posedge sys_clk) disable iff (rst)
    byteHit && !frameErrorAccessSelect |=>
    modeSelect == $past(sfrWriteData[7:6]))
    else $error("mode field not written");

  a_fe_sticky: assert property (@(posedge sys_clk) disable iff (rst)
    frameError_reg && !feSwClr |=> framingErrorFlag)
    else $error("frame error lost without software clear");

  a_fe_set: assert property (@(posedge sys_clk) disable iff (rst)
    rxFrameDone && rxEnable_reg && mode != SPC_MODE_SHIFT &&
    !rxStopBit |=> framingErrorFlag)
    else $error("missing stop bit did not set frame error");

  a_fast_rate: assert property (@(posedge sys_clk) disable iff (rst)
    fastTwice |=> shiftClockTick)
    else $error("fast shift tick not every two cycles");

  a_slow_gap: assert property (@(posedge sys_clk) disable iff (rst)
    shiftClockTick && slowRun |=>
    (!shiftClockTick || !slowRun)[*8])
    else $error("slow shift tick too early");

  a_mode1_reject: assert property (@(posedge sys_clk) disable iff (rst)
    rxQuiet and (mode == SPC_MODE_8BIT_VAR && mpCheck_reg &&
    rxFrameDone && !rxStopBit) |=> !rxDone_reg)
    else $error("mode 1 frame without stop bit accepted");

  a_mode23_reject: assert property (@(posedge sys_clk) disable iff (rst)
    rxQuiet and (mode[1] && mpCheck_reg && rxFrameDone &&
    !rxNinthBit) |=> !rxDone_reg && !rxAccepted)
    else $error("data frame accepted under address check");

  a_ren_off: assert property (@(posedge sys_clk) disable iff (rst)
    rxQuiet and (!rxEnable_reg && (rxFrameDone || rxShiftDone))
    |=> !rxDone_reg)
    else $error("frame taken while reception disabled");

  a_mode0_start: assert property (@(posedge sys_clk) disable iff (rst)
    rxDone_reg ##1 rxDone_reg |-> !mode0ReceiveStart)
    else $error("mode 0 start while receive flag set");

  a_tx_ninth: assert property (@(posedge sys_clk) disable iff (rst)
    ninthTransmitBit |-> modeSelect[1] && $past(txNinth_next))
    else $error("ninth transmit bit outside modes 2 and 3");

  a_rb8_stop: assert property (@(posedge sys_clk) disable iff (rst)
    rxValid && mode == SPC_MODE_8BIT_VAR |=>
    rxNinth_reg == $past(rxStopBit))
    else $error("stop level not stored in mode 1");

  a_tx_set: assert property (@(posedge sys_clk) disable iff (rst)
    txFrameDone |=> txDone_reg && serialIrq)
    else $error("transmit flag not set");

  a_rx_accept: assert property (@(posedge sys_clk) disable iff (rst)
    rxValid |=> rxDone_reg && rxAccepted && serialIrq)
    else $error("receive flag not set on valid frame");

  a_rx_sticky: assert property (@(posedge sys_clk) disable iff (rst)
    rxDone_reg && !rxSwClr |=> rxDone_reg)
    else $error("receive flag cleared by hardware");

  a_irq_level: assert property (@(posedge sys_clk) disable iff (rst)
    serialIrq == (txDone_reg || rxDone_reg))
    else $error("interrupt request does not follow flags");

endmodule

// file: spc_shift_divider.sv
// Shift clock tick generator for the synchronous shift mode
`timescale 1ns/10ps
module spc_shift_divider
  import spc_pkg::*;
#(
  parameter int SLOW_DIV = SPC_SHIFT_DIV_SLOW, // Slow divisor
  parameter int FAST_DIV = SPC_SHIFT_DIV_FAST, // Fast divisor
  parameter int CNT_W = SPC_SHIFT_CNT_W // Counter width
) (
  input wire logic sys_clk, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic runEnable, // Divider runs while high
  input wire logic fastSelect, // Fast divisor when high
  output logic shiftTick // One-cycle tick per period
);

  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] lastCount;

  // Terminal count for the selected rate
  assign lastCount = fastSelect ? CNT_W'(FAST_DIV - 1)
                                : CNT_W'(SLOW_DIV - 1);

  // Counter and tick, held at zero while stopped
  always_ff @(posedge sys_clk) begin
    if (rst || !runEnable) begin
      count_reg <= '0;
      shiftTick <= 1'b0;
    end else if (count_reg >= lastCount) begin
      count_reg <= '0;
      shiftTick <= 1'b1;
    end else begin
      count_reg <= count_reg + CNT_W'(1);
      shiftTick <= 1'b0;
    end
  end

endmodule

// file: testbench.sv
// Self-checking bench for the serial port 0 control block
`timescale 1ns/10ps
module testbench;
  import spc_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] sfrAddr = 8'h00, sfrWriteData = 8'h00, sfrBitAddr = 8'h00;
  logic sfrWrite = 1'b0, sfrBitWrite = 1'b0, sfrBitValue = 1'b0;
  logic frameErrorAccessSelect = 1'b0;
  logic [7:0] slaveAddress = 8'hC0, slaveAddressMask = 8'hFD;
  logic sendReq = 1'b0, shiftReq = 1'b0, txReq = 1'b0;
  logic [7:0] sendByte = 8'h00;
  logic sendNinth = 1'b0, sendStop = 1'b1;
  logic txFrameDone, rxShiftDone, rxFrameDone, rxNinthBit, rxStopBit;
  logic [7:0] rxByte, sfrReadData, rdData;
  logic [1:0] modeSelect;
  logic multiprocessorCheckEnable, receiveEnable, ninthTransmitBit;
  logic mode0ReceiveStart, shiftClockTick, serialIrq, rxAccepted;
  logic framingErrorFlag;
  int numErrors = 0;
  int checked = 0;
  int gap;

  // ==========================================================
  // Clock and units
  always #20 sys_clk = ~sys_clk;

  spc_serial_control u_dut (.sys_clk(sys_clk), .rst(rst),
    .sfrAddr(sfrAddr), .sfrWrite(sfrWrite), .sfrWriteData(sfrWriteData),
    .sfrBitAddr(sfrBitAddr), .sfrBitWrite(sfrBitWrite),
    .sfrBitValue(sfrBitValue), .sfrReadData(sfrReadData),
    .frameErrorAccessSelect(frameErrorAccessSelect),
    .slaveAddress(slaveAddress), .slaveAddressMask(slaveAddressMask),
    .txFrameDone(txFrameDone), .rxShiftDone(rxShiftDone),
    .rxFrameDone(rxFrameDone), .rxByte(rxByte), .rxNinthBit(rxNinthBit),
    .rxStopBit(rxStopBit), .modeSelect(modeSelect),
    .multiprocessorCheckEnable(multiprocessorCheckEnable),
    .receiveEnable(receiveEnable), .ninthTransmitBit(ninthTransmitBit),
    .mode0ReceiveStart(mode0ReceiveStart),
    .shiftClockTick(shiftClockTick), .serialIrq(serialIrq),
    .rxAccepted(rxAccepted), .framingErrorFlag(framingErrorFlag));

  spc_remote_model u_remote (.sys_clk(sys_clk), .rst(rst),
    .sendReq(sendReq), .shiftReq(shiftReq), .txReq(txReq),
    .sendByte(sendByte), .sendNinth(sendNinth), .sendStop(sendStop),
    .rxFrameDone(rxFrameDone), .rxShiftDone(rxShiftDone),
    .txFrameDone(txFrameDone), .rxByte(rxByte), .rxNinthBit(rxNinthBit),
    .rxStopBit(rxStopBit));

  // ==========================================================
  // Shared tasks
  task automatic chk(input string what, input logic [7:0] got,
    input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      numErrors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    sfrAddr = a;
    sfrWriteData = d;
    sfrWrite = 1'b1;
    @(negedge sys_clk);
    sfrWrite = 1'b0;
  endtask

  task automatic bwr(input logic [7:0] a, input logic v);
    @(negedge sys_clk);
    sfrBitAddr = a;
    sfrBitValue = v;
    sfrBitWrite = 1'b1;
    @(negedge sys_clk);
    sfrBitWrite = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(negedge sys_clk);
    sfrAddr = a;
    @(negedge sys_clk);
    rdData = sfrReadData;
  endtask

  // Offer one frame; returns where the accept pulse stands
  task automatic frame(input logic [7:0] b, input logic n, input logic s);
    @(negedge sys_clk);
    sendByte = b;
    sendNinth = n;
    sendStop = s;
    sendReq = 1'b1;
    @(negedge sys_clk);
    sendReq = 1'b0;
    @(negedge sys_clk);
  endtask

  // Cycles from one shift tick to the next, bounded
  task automatic tick_gap();
    gap = 0;
    while (shiftClockTick !== 1'b1 && gap < 40) begin
      @(negedge sys_clk);
      gap++;
    end
    gap = 0;
    do begin
      @(negedge sys_clk);
      gap++;
    end while (shiftClockTick !== 1'b1 && gap < 40);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    rd(SPC_CTRL_ADDR);
    chk("reset view", rdData, 8'h00);
    rd(8'h99);
    chk("unmapped", rdData, 8'h00);
  endtask

  task automatic t_modes();
    for (int m = 0; m < 4; m++) begin
      wr(SPC_CTRL_ADDR, {m[1:0], 6'h18});
      rd(SPC_CTRL_ADDR);
      chk("view", rdData, {m[1:0], 6'h18});
      chk("mode", {6'h0, modeSelect}, {6'h0, m[1:0]});
      chk("ren", {7'h0, receiveEnable}, {7'h0, m != 0});
      chk("tb8", {7'h0, ninthTransmitBit}, {7'h0, m[1]});
    end
    bwr(8'h9C, 1'b0);
    rd(SPC_CTRL_ADDR);
    chk("bit write", rdData, 8'hC8);
  endtask

  task automatic t_ferr();
    wr(SPC_CTRL_ADDR, 8'h40);
    frame(8'h55, 1'b0, 1'b0);
    chk("off accept", {7'h0, rxAccepted}, 8'h00);
    chk("off fe", {7'h0, framingErrorFlag}, 8'h00);
    wr(SPC_CTRL_ADDR, 8'h50);
    frame(8'h55, 1'b0, 1'b0);
    chk("bad stop ok", {7'h0, rxAccepted}, 8'h01);
    chk("fe set", {7'h0, framingErrorFlag}, 8'h01);
    wr(SPC_CTRL_ADDR, 8'h50);
    frame(8'h55, 1'b0, 1'b1);
    chk("fe sticky", {7'h0, framingErrorFlag}, 8'h01);
    frameErrorAccessSelect = 1'b1;
    rd(SPC_CTRL_ADDR);
    chk("fe view", rdData, 8'hD5);
    bwr(8'h9F, 1'b0);
    chk("fe clear", {7'h0, framingErrorFlag}, 8'h00);
    chk("mode kept", {6'h0, modeSelect}, 8'h01);
    frameErrorAccessSelect = 1'b0;
  endtask

  task automatic rx_case(input logic [1:0] m, input logic mp,
    input logic [7:0] b, input logic n, input logic s, input logic acc,
    input logic rb);
    wr(SPC_CTRL_ADDR, {m, mp, 5'h10});
    chk("mp bit", {7'h0, multiprocessorCheckEnable}, {7'h0, mp});
    frame(b, n, s);
    chk("accept", {7'h0, rxAccepted}, {7'h0, acc});
    chk("irq", {7'h0, serialIrq}, {7'h0, acc});
    rd(SPC_CTRL_ADDR);
    chk("accept drop", {7'h0, rxAccepted}, 8'h00);
    chk("rx flag", {7'h0, rdData[0]}, {7'h0, acc});
    if (acc) chk("rb8", {7'h0, rdData[2]}, {7'h0, rb});
  endtask

  task automatic t_mp();
    rx_case(2'h1, 1'b0, 8'hC1, 1'b0, 1'b0, 1'b1, 1'b0);
    rx_case(2'h1, 1'b1, 8'hC2, 1'b0, 1'b1, 1'b1, 1'b1);
    rx_case(2'h1, 1'b1, 8'hC2, 1'b1, 1'b0, 1'b0, 1'b0);
    rx_case(2'h1, 1'b1, 8'hC1, 1'b1, 1'b1, 1'b0, 1'b0);
    rx_case(2'h2, 1'b1, 8'hFF, 1'b1, 1'b0, 1'b1, 1'b1);
    rx_case(2'h3, 1'b1, 8'hC2, 1'b0, 1'b1, 1'b0, 1'b0);
    rx_case(2'h3, 1'b0, 8'hC1, 1'b0, 1'b1, 1'b1, 1'b0);
  endtask

  task automatic t_mode0();
    wr(SPC_CTRL_ADDR, 8'h10);
    chk("m0 start", {7'h0, mode0ReceiveStart}, 8'h01);
    tick_gap();
    chk("slow gap", gap[7:0], 8'h0C);
    bwr(8'h9D, 1'b1);
    tick_gap();
    chk("fast gap", gap[7:0], 8'h02);
    @(negedge sys_clk);
    shiftReq = 1'b1;
    @(negedge sys_clk);
    shiftReq = 1'b0;
    rd(SPC_CTRL_ADDR);
    chk("m0 flag", {7'h0, rdData[0]}, 8'h01);
    chk("m0 hold", {7'h0, mode0ReceiveStart}, 8'h00);
  endtask

  task automatic t_tx();
    wr(SPC_CTRL_ADDR, 8'h80);
    @(negedge sys_clk);
    txReq = 1'b1;
    @(negedge sys_clk);
    txReq = 1'b0;
    @(negedge sys_clk);
    chk("tx irq", {7'h0, serialIrq}, 8'h01);
    repeat (20) @(negedge sys_clk);
    rd(SPC_CTRL_ADDR);
    chk("tx flag", rdData, 8'h82);
    bwr(8'h99, 1'b0);
    @(negedge sys_clk);
    chk("tx clear", {7'h0, serialIrq}, 8'h00);
  endtask

  // ==========================================================
  // Verdict, main sequence and watchdog
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, numErrors);
    if (numErrors == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    t_reset();
    t_modes();
    t_ferr();
    t_mp();
    t_mode0();
    t_tx();
    finish_test();
  end

  initial begin
    repeat (5000) @(posedge sys_clk);
    numErrors++;
    finish_test();
  end
endmodule
